// >>> scbc_map.vh
// Register map, command codes and timing constants of the command block
`ifndef SCBC_MAP_VH
`define SCBC_MAP_VH

// Register word indexes; byte address is four times the index
`define SCBC_REG_CTRL 4'h0
`define SCBC_REG_CMD 4'h1
`define SCBC_REG_LBA 4'h2
`define SCBC_REG_BUF 4'h3
`define SCBC_REG_BCNT 4'h4
`define SCBC_REG_BLK 4'h5
`define SCBC_REG_OPT 4'h6
`define SCBC_REG_PACE 4'h7
`define SCBC_REG_END_INT 4'h8
`define SCBC_REG_STAT 4'h9

// Control register fields
`define SCBC_CTRL_GO 0
`define SCBC_CTRL_UNIT_HI 7
`define SCBC_CTRL_UNIT_LO 4

// Command words, with the two option bits masked out
`define SCBC_OP_MASK 16'hff3f
`define SCBC_OP_INFO 16'h1c0a
`define SCBC_OP_READ 16'h1c01
`define SCBC_OP_CAP 16'h1c09

// Target operation codes
`define SCBC_TGT_READ 8'h28
`define SCBC_TGT_CAP 8'h25

// Transfer sizes in 16-bit words; the read size limit in bytes
`define SCBC_INFO_WORDS 24'h00_0009
`define SCBC_CAP_WORDS 24'h00_0004
`define SCBC_MAX_BYTES 32'h00ff_ffff

// Fixed information block contents
`define SCBC_INT_LEVEL 8'h0e
`define SCBC_NUM_PUN 8'h07
`define SCBC_NUM_LUN 8'h08
`define SCBC_NUM_LDN 8'h10
`define SCBC_CONN_32 4'h0
`define SCBC_CONN_16 4'h1

// Timing: reported figures, cycles derived at 100 MHz
`define SCBC_CLK_HZ 64'd100000000
`define SCBC_BUSY_MAX_S 8'h1e
`define SCBC_INT_OFF_US 8'h01
`define SCBC_BUSY_CYCLES (`SCBC_BUSY_MAX_S * `SCBC_CLK_HZ)

// Status bits
`define SCBC_ST_OK 0
`define SCBC_ST_LIMIT 1
`define SCBC_ST_BADCMD 2

`endif

// >>> scbc_cmd.v
// Command block interpreter: info, read data and read capacity
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "scbc_map.vh"

// Contract
// - Info command writes status block to buffer
// - Word 0 holds fixed identification code
// - Word 1 holds option registers two, three
// - Word 2 holds option four, level 0E
// - Word 3 top nibble reports connector width
// - Word 4 holds unit and LUN counts
// - Word 5 high byte reports sixteen devices
// - Word 5 low byte is pacing factor
// - Word 6 high byte busy time; obeyed
// - Word 6 low byte interrupt-off time; obeyed
// - Read data issues target read, moves blocks
// - Read limited to 65535 blocks, 16MB-1
// - Capacity command returns capacity block
module scbc_cmd #(
  parameter [63:0] BUSY_CYCLES = `SCBC_BUSY_CYCLES,
  parameter [15:0] ID_CODE = 16'h5a3c, // Arbitrary identification value
  parameter [7:0] END_INT_CODE = 8'h02 // End-of-interrupt request code
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire conn_16bit_pin,
  output wire tgt_req_valid,
  input wire tgt_req_ready,
  output reg [7:0] tgt_op,
  output reg [3:0] tgt_unit,
  output reg [31:0] tgt_lba,
  output reg [15:0] tgt_blocks,
  output reg [15:0] tgt_blklen,
  input wire tgt_dvalid,
  input wire [15:0] tgt_ddata,
  output wire tgt_dready,
  output reg dma_valid,
  input wire dma_ready,
  output reg [31:0] dma_addr,
  output reg [15:0] dma_data,
  output reg dma_last,
  output reg busy,
  output reg intr
);

  // One-hot states
  // One bit per state; a stray code falls back to idle
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_INFO = 5'b00010;
  localparam [4:0] S_ISSUE = 5'b00100;
  localparam [4:0] S_XFER = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;

  // Command block registers loaded by software, then the status result
  // Loaded ones written only while idle, so a running command sees a frozen copy; stat_r is set by the sequencer
  reg [31:0] cmd_r; // Enable word high, command word low
  reg [31:0] lba_r; // Logical block address
  reg [31:0] buf_r; // System buffer address
  reg [31:0] bcnt_r; // System buffer byte count
  reg [31:0] blk_r; // Block length high, block count low
  reg [23:0] opt_r; // Option-select registers 4, 3, 2
  reg [7:0] pace_r; // DMA pacing factor in percent
  reg [2:0] stat_r; // Outcome of the last command

  // Sequencer state
  reg [4:0] state_r;
  reg [23:0] left_r; // Words still to be presented
  reg [3:0] idx_r; // Info block word index
  reg [31:0] next_addr_r; // Address of the next word
  reg [63:0] busy_cnt_r; // Time since reset release, held once busy drops
  reg rd_done_r; // Read answer stands this cycle

  // Connector strap synchroniser, three stages
  reg conn_s1_r;
  reg conn_s2_r;
  reg conn_s3_r;
  reg conn_16_r; // Filtered connector width

  // Command word with the two option bits masked off
  wire [15:0] opcode = cmd_r[15:0] & `SCBC_OP_MASK;
  // Read size in bytes; 16 by 16 bits always fits in 32
  wire [31:0] total = blk_r[31:16] * blk_r[15:0];
  // Output stage takes a word when empty or emptying this cycle
  wire slot_free = !dma_valid || dma_ready;
  wire wr_ctrl = avs_write && (avs_address == `SCBC_REG_CTRL);
  wire go = wr_ctrl && avs_writedata[`SCBC_CTRL_GO];
  // Only the agreed end code clears the flag; other values are ignored
  wire end_int_wr = avs_write && (avs_address == `SCBC_REG_END_INT) &&
                    (avs_writedata[7:0] == END_INT_CODE);
  // Info words are made here, read words come from the target
  wire info_load = (state_r == S_INFO) && (left_r != 24'h00_0000) &&
                   slot_free;
  wire xfer_load = tgt_dvalid && tgt_dready;
  wire load = info_load || xfer_load;
  // Finished once every word is counted and the stage is empty
  wire drained = (left_r == 24'h00_0000) && !dma_valid;

  // Word of the information block selected by index
  function [15:0] info_word;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: info_word = ID_CODE;
        4'h1: info_word = {opt_r[7:0], opt_r[15:8]};
        4'h2: info_word = {opt_r[23:16], `SCBC_INT_LEVEL};
        4'h3: info_word = {(conn_16_r ? `SCBC_CONN_16 : `SCBC_CONN_32),
                           12'h000};
        4'h4: info_word = {`SCBC_NUM_PUN, `SCBC_NUM_LUN};
        4'h5: info_word = {`SCBC_NUM_LDN, pace_r};
        4'h6: info_word = {`SCBC_BUSY_MAX_S, `SCBC_INT_OFF_US};
        default: info_word = 16'h0000; // Words 7 and 8 reserved
      endcase
    end
  endfunction

  // Word count of a transfer in bytes; an odd byte rounds up
  // Within the size limit the sum fits in bits 24 to 0
  function [23:0] words_of;
    input [31:0] bytes;
    reg [31:0] sum;
    begin
      sum = bytes + 32'h0000_0001;
      words_of = sum[24:1];
    end
  endfunction

  // Target request stands while waiting for acceptance
  assign tgt_req_valid = (state_r == S_ISSUE);
  // Target data stalls whenever the output stage is full and not emptying this cycle
  assign tgt_dready = (state_r == S_XFER) && slot_free &&
                      (left_r != 24'h00_0000);
  // Reads take one wait state so read data come from a flop
  assign avs_waitrequest = avs_read && !rd_done_r;

  // Strap synchroniser; only stages two and three are compared
  // A pulse shorter than two cycles never reaches the filtered value
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conn_s1_r <= 1'b0;
      conn_s2_r <= 1'b0;
      conn_s3_r <= 1'b0;
      conn_16_r <= 1'b0;
    end else begin
      conn_s1_r <= conn_16bit_pin;
      conn_s2_r <= conn_s1_r;
      conn_s3_r <= conn_s2_r;
      if (conn_s2_r == conn_s3_r) begin
        conn_16_r <= conn_s3_r;
      end
    end
  end

  // Busy after reset until the initialisation time has run out
  // 64 bits so the full thirty-second figure fits at any clock rate
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_r <= 64'h0000_0000_0000_0000;
      busy <= 1'b1;
    end else if (busy) begin
      // Counter stops with busy, so it never wraps
      busy_cnt_r <= busy_cnt_r + 64'h0000_0000_0000_0001;
      if (busy_cnt_r >= BUSY_CYCLES - 64'h0000_0000_0000_0001) begin
        busy <= 1'b0;
      end
    end
  end

  // Software-written registers
  // Byte count is kept for readback; length comes from the block fields
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= 32'h0000_0000;
      lba_r <= 32'h0000_0000;
      buf_r <= 32'h0000_0000;
      bcnt_r <= 32'h0000_0000;
      blk_r <= 32'h0000_0000;
      opt_r <= 24'h00_0000;
      pace_r <= 8'h00;
    end else if (avs_write && (state_r == S_IDLE)) begin
      // Command block is frozen while a command runs
      case (avs_address)
        `SCBC_REG_CMD: cmd_r <= avs_writedata;
        `SCBC_REG_LBA: lba_r <= avs_writedata;
        `SCBC_REG_BUF: buf_r <= avs_writedata;
        `SCBC_REG_BCNT: bcnt_r <= avs_writedata;
        `SCBC_REG_BLK: blk_r <= avs_writedata;
        `SCBC_REG_OPT: opt_r <= avs_writedata[23:0];
        `SCBC_REG_PACE: pace_r <= avs_writedata[7:0];
        default: begin
          // Other offsets store nothing here
        end
      endcase
    end
  end

  // Bus read answer, registered
  // One wait state per read buys a flopped read data path
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_done_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done_r <= avs_read && !rd_done_r;
      if (avs_read && !rd_done_r) begin
        case (avs_address)
          `SCBC_REG_CTRL: avs_readdata <= {29'h0000_0000, intr,
                                           (state_r != S_IDLE), busy};
          `SCBC_REG_CMD: avs_readdata <= cmd_r;
          `SCBC_REG_LBA: avs_readdata <= lba_r;
          `SCBC_REG_BUF: avs_readdata <= buf_r;
          `SCBC_REG_BCNT: avs_readdata <= bcnt_r;
          `SCBC_REG_BLK: avs_readdata <= blk_r;
          `SCBC_REG_OPT: avs_readdata <= {8'h00, opt_r};
          `SCBC_REG_PACE: avs_readdata <= {24'h00_0000, pace_r};
          `SCBC_REG_STAT: avs_readdata <= {29'h0000_0000, stat_r};
          default: avs_readdata <= 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end

  // Completion flag: set by the end of a command, cleared by end code
  // Clearing takes one cycle, far below the reported microsecond
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intr <= 1'b0;
    end else if (state_r == S_DONE) begin
      intr <= 1'b1; // Set wins over a clear in the same cycle
    end else if (end_int_wr) begin
      intr <= 1'b0;
    end
  end

  // Output word stage toward system memory
  // A new word may load in the same cycle the old one is taken
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_valid <= 1'b0;
      dma_data <= 16'h0000;
      dma_addr <= 32'h0000_0000;
      dma_last <= 1'b0;
    end else if (load) begin
      dma_valid <= 1'b1;
      dma_data <= info_load ? info_word(idx_r) : tgt_ddata;
      dma_addr <= next_addr_r;
      dma_last <= (left_r == 24'h00_0001);
    end else if (dma_ready) begin
      // Nothing new: the stage empties once the sink takes the word
      dma_valid <= 1'b0;
    end
  end

  // Command sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      left_r <= 24'h00_0000;
      idx_r <= 4'h0;
      next_addr_r <= 32'h0000_0000;
      stat_r <= 3'b000;
      tgt_op <= 8'h00;
      tgt_unit <= 4'h0;
      tgt_lba <= 32'h0000_0000;
      tgt_blocks <= 16'h0000;
      tgt_blklen <= 16'h0000;
    end else begin
      // Address and count advance on every word loaded
      if (load) begin
        next_addr_r <= next_addr_r + 32'h0000_0002;
        left_r <= left_r - 24'h00_0001;
        idx_r <= idx_r + 4'h1;
      end
      case (state_r)
        S_IDLE: begin
          // A start while still busy from reset is ignored
          if (go && !busy) begin
            next_addr_r <= buf_r;
            idx_r <= 4'h0;
            stat_r <= 3'b000;
            tgt_unit <= avs_writedata[`SCBC_CTRL_UNIT_HI:`SCBC_CTRL_UNIT_LO];
            tgt_lba <= lba_r;
            tgt_blocks <= blk_r[15:0];
            tgt_blklen <= blk_r[31:16];
            if (opcode == `SCBC_OP_INFO) begin
              left_r <= `SCBC_INFO_WORDS;
              state_r <= S_INFO;
            end else if (opcode == `SCBC_OP_READ) begin
              // Zero-block-count or oversize reads end at once with a limit error
              if ((blk_r[15:0] == 16'h0000) ||
                  (total > `SCBC_MAX_BYTES)) begin
                stat_r[`SCBC_ST_LIMIT] <= 1'b1;
                state_r <= S_DONE;
              end else begin
                left_r <= words_of(total);
                tgt_op <= `SCBC_TGT_READ;
                state_r <= S_ISSUE;
              end
            end else if (opcode == `SCBC_OP_CAP) begin
              left_r <= `SCBC_CAP_WORDS;
              tgt_op <= `SCBC_TGT_CAP;
              state_r <= S_ISSUE;
            end else begin
              stat_r[`SCBC_ST_BADCMD] <= 1'b1;
              state_r <= S_DONE;
            end
          end
        end
        S_INFO: begin
          if (drained) begin
            stat_r[`SCBC_ST_OK] <= 1'b1;
            state_r <= S_DONE;
          end
        end
        S_ISSUE: begin
          // Fields were captured at start and stand until ready
          if (tgt_req_ready) begin
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          // Ends only after the last word has left the stage
          if (drained) begin
            stat_r[`SCBC_ST_OK] <= 1'b1;
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          // One cycle here raises the completion flag
          state_r <= S_IDLE;
        end
        default: begin
          // Any code off the one-hot set recovers to idle
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> scbc_chk_asserts.sv
// Port-level concurrent checks for the command block interpreter
`timescale 1ns/10ps
`include "scbc_map.vh"
module scbc_chk #(
  parameter [63:0] BUSY_CYCLES = 64'd20,
  parameter [7:0] END_INT_CODE = 8'h02
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire tgt_req_valid,
  input wire tgt_req_ready,
  input wire [7:0] tgt_op,
  input wire [31:0] tgt_lba,
  input wire [15:0] tgt_blocks,
  input wire [15:0] tgt_blklen,
  input wire tgt_dready,
  input wire dma_valid,
  input wire dma_ready,
  input wire [31:0] dma_addr,
  input wire [15:0] dma_data,
  input wire dma_last,
  input wire busy,
  input wire intr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Edges since reset; saturates so a long run cannot wrap
  reg [31:0] up_r;
  // Address the following DMA word must carry
  reg [31:0] next_r;
  // Set between words of one transfer
  reg armed_r;
  wire dma_take = dma_valid && dma_ready;
  // Track uptime and the expected next DMA address
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_r <= 32'h0000_0000;
      next_r <= 32'h0000_0000;
      armed_r <= 1'b0;
    end else begin
      if (up_r != 32'hffff_ffff) up_r <= up_r + 32'h0000_0001;
      if (dma_take) begin
        next_r <= dma_addr + 32'h0000_0002;
        armed_r <= !dma_last;
      end
    end
  end
  a_busy_drop: assert property (up_r > BUSY_CYCLES + 2 |-> !busy)
    else $error("busy still high after limit");
  a_intr_clear: assert property (intr && avs_write &&
    avs_address == `SCBC_REG_END_INT &&
    avs_writedata[7:0] == END_INT_CODE |=> !intr)
    else $error("intr not cleared by end code");
  a_read_limit: assert property (tgt_req_valid &&
    tgt_op == `SCBC_TGT_READ |-> tgt_blocks != 16'h0000 &&
    {16'h0000, tgt_blocks} * tgt_blklen <= `SCBC_MAX_BYTES)
    else $error("read request beyond size limit");
  a_req_hold: assert property (tgt_req_valid && !tgt_req_ready |=>
    tgt_req_valid && $stable({tgt_op, tgt_lba, tgt_blocks, tgt_blklen}))
    else $error("target request changed before ready");
  a_dma_hold: assert property (dma_valid && !dma_ready |=>
    dma_valid && $stable({dma_addr, dma_data, dma_last}))
    else $error("dma word changed before ready");
  a_addr_step: assert property (dma_valid && armed_r |->
    dma_addr == next_r)
    else $error("dma address not two past previous");
  a_done_intr: assert property (dma_take && dma_last |-> ##[1:3] intr)
    else $error("no intr after final word");
  a_flow_gate: assert property (tgt_dready |-> !dma_valid || dma_ready)
    else $error("target data taken while dma stalled");
  a_tgt_code: assert property (tgt_req_valid |->
    tgt_op == `SCBC_TGT_READ || tgt_op == `SCBC_TGT_CAP)
    else $error("unknown target operation");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_read_wait: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("read wait longer than one cycle");
  c_last: cover property (dma_take && dma_last);
  c_req: cover property (tgt_req_valid && tgt_req_ready);
  c_stall: cover property (dma_valid && !dma_ready);
endmodule
bind scbc_cmd scbc_chk #(.BUSY_CYCLES(BUSY_CYCLES),
  .END_INT_CODE(END_INT_CODE)) i_chk (.*);

// >>> scbc_tgt_model.sv
// Behavioural fixed-block target answering read and capacity requests
`timescale 1ns/10ps
`include "scbc_map.vh"
module scbc_tgt_model (
  input wire clk,
  input wire sys_rst,
  input wire slow,
  input wire tgt_req_valid,
  output reg tgt_req_ready,
  input wire [7:0] tgt_op,
  input wire [15:0] tgt_blocks,
  input wire [15:0] tgt_blklen,
  output wire tgt_dvalid,
  output wire [15:0] tgt_ddata,
  input wire tgt_dready
);
  reg [31:0] left_r; // Words still to send
  reg [15:0] idx_r; // Index of the word on offer
  reg [15:0] last_r; // Last word sent
  reg gap_r; // Idle cycle after each word when slow
  reg [7:0] op_r; // Operation being served
  wire take = tgt_dvalid && tgt_dready;
  wire [15:0] word = (op_r == `SCBC_TGT_CAP ? 16'hc000 : 16'ha000) | idx_r;
  assign tgt_dvalid = (left_r != 32'h0000_0000) && !gap_r;
  // Idle data shows the inverse, so a stale sample cannot pass
  assign tgt_ddata = tgt_dvalid ? word : ~last_r;
  // Accept one request, then stream its words
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgt_req_ready <= 1'b0;
      left_r <= 32'h0000_0000;
      idx_r <= 16'h0000;
      last_r <= 16'h0000;
      gap_r <= 1'b0;
      op_r <= 8'h00;
    end else begin
      tgt_req_ready <= tgt_req_valid && !tgt_req_ready;
      gap_r <= take && slow;
      if (tgt_req_valid && tgt_req_ready) begin
        op_r <= tgt_op;
        idx_r <= 16'h0000;
        if (tgt_op == `SCBC_TGT_CAP) left_r <= 32'h0000_0004;
        else left_r <= ({16'h0000, tgt_blocks} * tgt_blklen + 32'h0000_0001)
          >> 1;
      end else if (take) begin
        left_r <= left_r - 32'h0000_0001;
        idx_r <= idx_r + 16'h0001;
        last_r <= word;
      end
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the command block interpreter
`timescale 1ns/10ps
`include "scbc_map.vh"
module tb_top;
  localparam [15:0] ID = 16'h5a3c; // Arbitrary identification value
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0000_0000;
  reg conn_16bit_pin = 1'b0;
  reg dma_ready = 1'b1;
  reg slow = 1'b0;
  reg stall = 1'b0;
  wire [31:0] avs_readdata, tgt_lba, dma_addr;
  wire [15:0] tgt_blocks, tgt_blklen, tgt_ddata, dma_data;
  wire [7:0] tgt_op;
  wire [3:0] tgt_unit;
  wire avs_waitrequest, tgt_req_valid, tgt_req_ready, tgt_dvalid;
  wire tgt_dready, dma_valid, dma_last, busy, intr;
  integer num_errors = 0, num_checks = 0, n = 0, reqs = 0, cyc = 0, i, p;
  reg [15:0] got_d [0:15];
  reg [31:0] got_a [0:15];
  reg [15:0] got_l, ew [0:8];
  reg [47:0] tq;
  reg [31:0] rd, lba_q;
  scbc_cmd #(.BUSY_CYCLES(64'd20), .ID_CODE(ID)) i_dut (.*);
  scbc_tgt_model i_tgt (.clk(clk), .sys_rst(sys_rst), .slow(slow),
    .tgt_req_valid(tgt_req_valid), .tgt_req_ready(tgt_req_ready),
    .tgt_op(tgt_op), .tgt_blocks(tgt_blocks), .tgt_blklen(tgt_blklen),
    .tgt_dvalid(tgt_dvalid), .tgt_ddata(tgt_ddata),
    .tgt_dready(tgt_dready));
  always #5 clk = ~clk;
  // Timeout, stalling DMA sink and capture of both traffic streams
  always @(posedge clk) begin
    cyc <= cyc + 1;
    dma_ready <= stall ? ~dma_ready : 1'b1;
    if (dma_valid && dma_ready && n < 16) begin
      got_d[n] <= dma_data;
      got_a[n] <= dma_addr;
      got_l[n] <= dma_last;
      n <= n + 1;
    end
    if (tgt_req_valid && tgt_req_ready) begin
      reqs <= reqs + 1;
      tq <= {tgt_op, tgt_unit, 4'h0, tgt_blocks, tgt_blklen};
      lba_q <= tgt_lba;
    end
    // Timeout last, so nothing in this block follows the finish
    if (cyc > 20000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  task chk(input [47:0] g, input [47:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
    end
  endtask
  task rdr(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
    end
  endtask
  // Start a command on unit 5, wait for intr, check status and addresses
  task run(input [31:0] c, input integer w, input [2:0] st);
    integer k;
    begin
      wr(`SCBC_REG_BUF, 32'h0000_1000);
      wr(`SCBC_REG_CMD, c);
      n = 0;
      wr(`SCBC_REG_CTRL, 32'h0000_0051);
      rd = 32'h0000_0000;
      for (k = 0; k < 300 && rd[2] !== 1'b1; k = k + 1)
        rdr(`SCBC_REG_CTRL, rd);
      chk(rd[2], 1'b1);
      rdr(`SCBC_REG_STAT, rd);
      chk(rd[2:0], st);
      chk(n, w);
      for (k = 0; k < w; k = k + 1) begin
        chk(got_a[k], 32'h0000_1000 + 2 * k);
        chk(got_l[k], k == w - 1);
      end
      wr(`SCBC_REG_END_INT, 32'h0000_0003);
      rdr(`SCBC_REG_CTRL, rd);
      chk(rd[2], 1'b1);
      wr(`SCBC_REG_END_INT, 32'h0000_0002);
      rdr(`SCBC_REG_CTRL, rd);
      chk(rd[2], 1'b0);
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rdr(`SCBC_REG_CTRL, rd);
    chk(rd[0], 1'b1);
    for (i = 0; i < 40 && rd[0] !== 1'b0; i = i + 1)
      rdr(`SCBC_REG_CTRL, rd);
    chk(rd[0], 1'b0);
    $display("test busy done");
    for (p = 0; p < 2; p = p + 1) begin
      conn_16bit_pin <= p;
      stall <= p;
      wr(`SCBC_REG_OPT, {8'h00, 8'h44 + p[7:0], 8'h33, 8'h22});
      wr(`SCBC_REG_PACE, 32'h0000_004b - p);
      wr(`SCBC_REG_BCNT, 32'h0000_0012);
      run(32'h8200_1c0a, 9, 3'b001);
      ew[0] = ID;
      ew[1] = 16'h2233;
      ew[2] = {8'h44 + p[7:0], 8'h0e};
      ew[3] = {p[3:0], 12'h000};
      ew[4] = 16'h0708;
      ew[5] = {8'h10, 8'h4b - p[7:0]};
      ew[6] = 16'h1e01;
      ew[7] = 16'h0000;
      ew[8] = 16'h0000;
      for (i = 0; i < 9; i = i + 1) chk(got_d[i], ew[i]);
      $display("test info %0d done", p);
    end
    slow <= 1'b1;
    wr(`SCBC_REG_LBA, 32'h0001_2345);
    wr(`SCBC_REG_BLK, {16'd5, 16'd3});
    wr(`SCBC_REG_BCNT, 32'h0000_000f);
    run(32'h8200_1c81, 8, 3'b001);
    chk(tq, {8'h28, 8'h50, 16'd3, 16'd5});
    chk(lba_q, 32'h0001_2345);
    for (i = 0; i < 8; i = i + 1) chk(got_d[i], 16'ha000 + i);
    $display("test read done");
    slow <= 1'b0;
    stall <= 1'b0;
    run(32'h8200_1c09, 4, 3'b001);
    chk(tq[47:40], 8'h25);
    for (i = 0; i < 4; i = i + 1) chk(got_d[i], 16'hc000 + i);
    $display("test capacity done");
    p = reqs;
    wr(`SCBC_REG_BLK, {16'h0101, 16'hffff});
    run(32'h8200_1c01, 0, 3'b010);
    wr(`SCBC_REG_BLK, {16'd512, 16'd0});
    run(32'h8200_1c01, 0, 3'b010);
    run(32'h8200_1c05, 0, 3'b100);
    chk(reqs, p);
    rdr(4'hf, rd);
    chk(rd, 32'h0000_0000);
    $display("test limits done");
    complete_run;
  end
endmodule
